/* common/svc_pkg.sv */
// Function
// - List end marker is two 16-bit words
// - End word: bits 14,15 set; header bit15 clear
// - Second end word gives last telegram finish time
// - Container: five control words plus buffer
// - Role select picks master or slave coding
// - Master word 0: handshake, direction, final, element
// - Final request forces outgoing end bit
// - Master stall bit mirrors awaiting microprocessor
// - Tx info words per cycle, one to four
// - Master flags: slave error, buffer ends
// - Master copies reply bits into word 1
// - Word 1 bit 7 marks bad transfer
// - Master rx info words per cycle, one to four
// - Word 2: tx current and final index
// - Word 3: rx current and final index
// - Fault tally counts mismatches or busy cycles
// - Master fault flags in word 4
// - Slave word 0 reply bits, busy when pending
// - Slave element code and direction bits
// - Slave flags element change, tx buffer end
// - Role select comes from svc_role_select input
// - Base pointers at RAM words two to nine
package svc_pkg;
  typedef logic [10:0] addr_t;
  typedef logic [15:0] word_t;

  localparam addr_t PTR_TABLE_BASE = 11'h002;
  localparam addr_t BUF_OFFSET     = 11'h005;
  localparam logic [2:0] LAST_CTRL = 3'h4;

  localparam int W_REQ    = 0;
  localparam int W_REPLY  = 1;
  localparam int W_TXIDX  = 2;
  localparam int W_RXIDX  = 3;
  localparam int W_TALLY  = 4;

  localparam int TAG_LO   = 14;
  localparam int TAG_HI   = 15;

  localparam int B_HS      = 0;
  localparam int B_DIR     = 1;
  localparam int B_FINAL   = 2;
  localparam int B_CODE_LO = 3;
  localparam int B_FINAL_REQ = 6;
  localparam int B_MBUSY   = 7;
  localparam int B_CNT_LO  = 8;
  localparam int B_ERRFLAG = 12;
  localparam int B_TXEND   = 13;
  localparam int B_RXEND   = 14;
  localparam int B_BAD     = 7;
  localparam int B_TSRC    = 8;
  localparam int B_PROTO   = 9;
  localparam int B_HSTO    = 10;
  localparam int B_BUSYTO  = 11;
  localparam int B_CMDFLAG = 12;
  localparam int B_S_BUSY  = 1;
  localparam int B_S_CODE  = 4;
  localparam int B_S_DIR   = 7;

  localparam logic [7:0] TALLY_MAX = 8'hFF;

  typedef enum logic [2:0] {
    SM_IDLE = 3'b000,
    SM_PTR  = 3'b001,
    SM_RDW  = 3'b010,
    SM_XFER = 3'b011,
    SM_WBK  = 3'b100,
    SM_LST  = 3'b101,
    SM_LSTT = 3'b110
  } state_t;
endpackage : svc_pkg

/* logic/list_end_check.sv */
`timescale 1ns/1ps
module list_end_check (
  input  wire logic         clk,              // Controller clock
  input  wire logic         reset,            // Synchronous reset
  input  wire logic         first_valid,      // First list word present
  input  wire logic         second_valid,     // Second end word present
  input  wire svc_pkg::word_t word,           // Word read from RAM
  output logic              is_end,           // First word is end marker
  output logic              is_header,        // First word is a header
  output svc_pkg::word_t    list_finish_time  // Captured finish time
);
  import svc_pkg::*;

  typedef struct packed {
    word_t finish;
  } lec_state_t;

  lec_state_t s_q;
  lec_state_t s_d;

  assign is_end    = first_valid & word[TAG_HI] & word[TAG_LO];
  assign is_header = first_valid & ~word[TAG_HI];
  assign list_finish_time = s_q.finish;

  always_comb
  begin
    s_d = s_q;
    if (second_valid)
      s_d.finish = word;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule : list_end_check

/* logic/svc_engine.sv */
`timescale 1ns/1ps
module svc_engine (
  input  wire logic           clk,                // Controller clock
  input  wire logic           reset,              // Synchronous reset
  input  wire logic           cmd_tx,             // Build outgoing field
  input  wire logic           cmd_rx,             // Process received field
  input  wire logic           cmd_list,           // Check list word
  input  wire logic [2:0]     svc_index,          // Container number
  input  wire logic           svc_role_select,    // 1 master, 0 slave
  input  wire svc_pkg::addr_t list_addr,          // List word address
  input  wire logic           rx_handshake,       // Received handshake
  input  wire logic           rx_busy,            // Received busy
  input  wire logic           rx_error,           // Received error
  input  wire logic           rx_cmd_change,      // Received cmd change
  input  wire logic           rx_good,            // Transfer was correct
  input  wire logic [2:0]     rx_element_code,    // Received element
  input  wire logic           rx_direction,       // Received direction
  input  wire logic [63:0]    rx_words,           // Received info words
  input  wire logic           fault_protocol,     // Protocol error seen
  input  wire logic           fault_hs_timeout,   // Handshake timeout
  input  wire logic           fault_busy_timeout, // Busy timeout
  input  wire svc_pkg::word_t ram_rdata,          // RAM read data
  output svc_pkg::addr_t      ram_addr,           // RAM word address
  output logic                ram_rd,             // RAM read strobe
  output logic                ram_we,             // RAM write strobe
  output svc_pkg::word_t      ram_wdata,          // RAM write data
  output svc_pkg::word_t      svc_field,          // Outgoing service bits
  output logic                field_valid,        // Field strobe
  output logic                info_valid,         // Info word strobe
  output svc_pkg::word_t      info_word,          // Outgoing info word
  output logic                svc_done,           // Operation finished
  output logic                engine_busy,        // Operation running
  output logic                list_end,           // End marker found
  output logic                list_header,        // Header found
  output svc_pkg::word_t      list_finish_time    // Last finish time
);
  import svc_pkg::*;

  typedef struct packed {
    state_t           fsm;
    logic [2:0]       cnt;
    logic [2:0]       left;
    logic [1:0]       k;
    logic [4:0][15:0] w;
    addr_t            base;
    logic             role;
    logic             is_rx;
    logic             hs;
    logic             busy;
    logic             err;
    logic             cmd;
    logic             good;
    logic [2:0]       code;
    logic             dir;
    logic             pf;
    logic             ht;
    logic             bt;
    logic [63:0]      words;
    logic             rd;
    logic             we;
    logic             cap;
    addr_t            addr;
    word_t            wdata;
    word_t            field;
    logic             fvalid;
    logic             ivalid;
    word_t            iword;
    logic             done;
    logic             lend;
    logic             lhead;
  } eng_state_t;

  eng_state_t s_q;
  eng_state_t s_d;

  logic is_end;
  logic is_header;

  list_end_check u_list_end_check (
    .clk              (clk),
    .reset            (reset),
    .first_valid      (s_q.cap && s_q.fsm == SM_LST),
    .second_valid     (s_q.cap && s_q.fsm == SM_LSTT),
    .word             (ram_rdata),
    .is_end           (is_end),
    .is_header        (is_header),
    .list_finish_time (list_finish_time)
  );

  assign ram_addr    = s_q.addr;
  assign ram_rd      = s_q.rd;
  assign ram_we      = s_q.we;
  assign ram_wdata   = s_q.wdata;
  assign svc_field   = s_q.field;
  assign field_valid = s_q.fvalid;
  assign info_valid  = s_q.ivalid;
  assign info_word   = s_q.iword;
  assign svc_done    = s_q.done;
  assign list_end    = s_q.lend;
  assign list_header = s_q.lhead;
  assign engine_busy = (s_q.fsm != SM_IDLE);

  function automatic addr_t buf_addr(addr_t base, logic [7:0] idx);
    buf_addr = base + BUF_OFFSET + addr_t'(idx);
  endfunction : buf_addr

  // Copy of word 0 as stored back, with the stall bit refreshed
  function automatic word_t req_out(word_t w0, logic role);
    word_t r;
    r = w0;
    if (role)
      r[B_MBUSY] = w0[B_ERRFLAG] | w0[B_TXEND] | w0[B_RXEND];
    else
      r[B_S_BUSY] = w0[B_S_BUSY] | w0[B_ERRFLAG] | w0[B_TXEND];
    req_out = r;
  endfunction : req_out

  always_comb
  begin
    logic [4:0][15:0] c;
    logic             stalled;
    logic             final_bit;
    logic             bump;
    logic [7:0]       idx;
    logic [7:0]       fin;
    c         = s_q.w;
    stalled   = 1'b0;
    final_bit = 1'b0;
    bump      = 1'b0;
    idx       = 8'h00;
    fin       = 8'h00;
    s_d        = s_q;
    s_d.rd     = 1'b0;
    s_d.we     = 1'b0;
    s_d.cap    = s_q.rd;
    s_d.fvalid = 1'b0;
    s_d.ivalid = 1'b0;
    s_d.done   = 1'b0;
    s_d.lend   = 1'b0;
    s_d.lhead  = 1'b0;
    unique case (s_q.fsm)
      SM_IDLE:
      begin
        if (cmd_list)
        begin
          s_d.addr = list_addr;
          s_d.rd   = 1'b1;
          s_d.fsm  = SM_LST;
        end
        else if (cmd_tx || cmd_rx)
        begin
          s_d.is_rx = cmd_rx;
          s_d.role  = svc_role_select;
          s_d.hs    = rx_handshake;
          s_d.busy  = rx_busy;
          s_d.err   = rx_error;
          s_d.cmd   = rx_cmd_change;
          s_d.good  = rx_good;
          s_d.code  = rx_element_code;
          s_d.dir   = rx_direction;
          s_d.pf    = fault_protocol;
          s_d.ht    = fault_hs_timeout;
          s_d.bt    = fault_busy_timeout;
          s_d.words = rx_words;
          s_d.addr  = PTR_TABLE_BASE + addr_t'(svc_index);
          s_d.rd    = 1'b1;
          s_d.fsm   = SM_PTR;
        end
      end
      SM_PTR:
      begin
        if (s_q.cap)
        begin
          s_d.base = ram_rdata[10:0];
          s_d.addr = ram_rdata[10:0];
          s_d.rd   = 1'b1;
          s_d.cnt  = 3'h0;
          s_d.fsm  = SM_RDW;
        end
      end
      SM_RDW:
      begin
        if (s_q.cap)
        begin
          c[s_q.cnt] = ram_rdata;
          if (s_q.cnt != LAST_CTRL)
          begin
            s_d.w    = c;
            s_d.cnt  = s_q.cnt + 3'h1;
            s_d.addr = s_q.base + addr_t'(s_q.cnt + 3'h1);
            s_d.rd   = 1'b1;
          end
          else
          begin
            s_d.left = 3'h0;
            s_d.k    = 2'h0;
            if (s_q.role)
            begin
              stalled = c[W_REQ][B_ERRFLAG] | c[W_REQ][B_TXEND]
                      | c[W_REQ][B_RXEND];
              if (!s_q.is_rx)
              begin
                final_bit = c[W_REQ][B_FINAL] | c[W_REQ][B_FINAL_REQ];
                c[W_REQ][B_FINAL] = final_bit;
                s_d.field = {10'h000, c[W_REQ][B_FINAL_REQ - 1:B_CODE_LO],
                             final_bit, c[W_REQ][B_DIR],
                             c[W_REQ][B_HS]};
                s_d.fvalid = 1'b1;
                if (!stalled)
                  s_d.left = {1'b0, c[W_REQ][B_CNT_LO +: 2]} + 3'h1;
              end
              else
              begin
                c[W_REPLY][3:0] = {s_q.cmd, s_q.err, s_q.busy,
                                   s_q.hs};
                c[W_REPLY][B_BAD] = ~s_q.good;
                c[W_REQ][B_ERRFLAG] = c[W_REQ][B_ERRFLAG] | s_q.err;
                c[W_TALLY][B_PROTO] = c[W_TALLY][B_PROTO] | s_q.pf;
                c[W_TALLY][B_HSTO] = c[W_TALLY][B_HSTO] | s_q.ht;
                c[W_TALLY][B_BUSYTO] = c[W_TALLY][B_BUSYTO] | s_q.bt;
                c[W_TALLY][B_CMDFLAG] = c[W_TALLY][B_CMDFLAG]
                                      | s_q.cmd;
                bump = c[W_TALLY][B_TSRC] ? s_q.busy
                     : (s_q.hs != c[W_REQ][B_HS]);
                if (bump && c[W_TALLY][7:0] != TALLY_MAX)
                  c[W_TALLY][7:0] = c[W_TALLY][7:0] + 8'h01;
                if (!stalled && !c[W_REQ][B_DIR] && s_q.good)
                  s_d.left = {1'b0, c[W_REPLY][B_CNT_LO +: 2]}
                           + 3'h1;
              end
            end
            else
            begin
              stalled = c[W_REQ][B_ERRFLAG] | c[W_REQ][B_TXEND];
              if (!s_q.is_rx)
              begin
                s_d.field = {12'h000, c[W_REQ][3:2],
                             c[W_REQ][B_S_BUSY] | stalled,
                             c[W_REQ][B_HS]};
                s_d.fvalid = 1'b1;
                if (!stalled)
                  s_d.left = {1'b0, c[W_REQ][B_CNT_LO +: 2]} + 3'h1;
              end
              else if (s_q.code != c[W_REQ][B_S_DIR - 1:B_S_CODE]
                       || s_q.dir != c[W_REQ][B_S_DIR])
              begin
                c[W_REQ][B_ERRFLAG] = 1'b1;
                c[W_REQ][B_S_DIR - 1:B_S_CODE] = s_q.code;
                c[W_REQ][B_S_DIR] = s_q.dir;
              end
            end
            s_d.w  = c;
            s_d.fsm = SM_XFER;
          end
        end
      end
      SM_XFER:
      begin
        idx = s_q.is_rx ? s_q.w[W_RXIDX][7:0] : s_q.w[W_TXIDX][7:0];
        fin = s_q.is_rx ? s_q.w[W_RXIDX][15:8] : s_q.w[W_TXIDX][15:8];
        if (s_q.is_rx)
        begin
          if (s_q.left == 3'h0)
          begin
            s_d.cnt = 3'h0;
            s_d.fsm = SM_WBK;
          end
          else
          begin
            s_d.we    = 1'b1;
            s_d.addr  = buf_addr(s_q.base, idx);
            s_d.wdata = s_q.words[{s_q.k, 4'h0} +: 16];
            s_d.k     = s_q.k + 2'h1;
            s_d.left  = s_q.left - 3'h1;
            if (idx == fin)
            begin
              s_d.w[W_REQ][B_RXEND] = 1'b1;
              s_d.left = 3'h0;
            end
            else
              s_d.w[W_RXIDX][7:0] = idx + 8'h01;
          end
        end
        else
        begin
          if (s_q.cap)
          begin
            s_d.ivalid = 1'b1;
            s_d.iword  = ram_rdata;
            s_d.left   = s_q.left - 3'h1;
            if (idx == fin)
            begin
              s_d.w[W_REQ][B_TXEND] = 1'b1;
              s_d.left = 3'h0;
            end
            else
              s_d.w[W_TXIDX][7:0] = idx + 8'h01;
          end
          if (!s_q.rd && s_d.left != 3'h0)
          begin
            s_d.rd   = 1'b1;
            s_d.addr = buf_addr(s_q.base, s_d.w[W_TXIDX][7:0]);
          end
          else if (!s_q.rd && !s_q.cap)
          begin
            s_d.cnt = 3'h0;
            s_d.fsm = SM_WBK;
          end
        end
      end
      SM_WBK:
      begin
        s_d.we    = 1'b1;
        s_d.addr  = s_q.base + addr_t'(s_q.cnt);
        s_d.wdata = (s_q.cnt == 3'h0) ? req_out(s_q.w[W_REQ], s_q.role)
                  : s_q.w[s_q.cnt];
        s_d.cnt   = s_q.cnt + 3'h1;
        if (s_q.cnt == LAST_CTRL)
        begin
          s_d.done = 1'b1;
          s_d.fsm  = SM_IDLE;
        end
      end
      SM_LST:
      begin
        if (s_q.cap)
        begin
          if (is_end)
          begin
            s_d.addr = s_q.addr + 11'h001;
            s_d.rd   = 1'b1;
            s_d.fsm  = SM_LSTT;
          end
          else
          begin
            s_d.lhead = is_header;
            s_d.done  = 1'b1;
            s_d.fsm   = SM_IDLE;
          end
        end
      end
      SM_LSTT:
      begin
        if (s_q.cap)
        begin
          s_d.lend = 1'b1;
          s_d.done = 1'b1;
          s_d.fsm  = SM_IDLE;
        end
      end
      default:
      begin
        s_d.fsm = SM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q    <= '0;
      s_q.fsm <= SM_IDLE;
    end
    else
      s_q <= s_d;
  end
endmodule : svc_engine

/* dv/svc_engine_properties.sv */
`timescale 1ns/1ps
module svc_engine_properties
  import svc_pkg::*;
(
  input wire logic           clk,              // Clock
  input wire logic           reset,            // Sync reset
  input wire logic           cmd_tx,           // Transmit command
  input wire logic           cmd_rx,           // Receive command
  input wire logic           cmd_list,         // List command
  input wire logic [2:0]     svc_index,        // Container number
  input wire svc_pkg::addr_t list_addr,        // List word address
  input wire svc_pkg::word_t ram_rdata,        // RAM data
  input wire svc_pkg::addr_t ram_addr,         // RAM address
  input wire logic           ram_rd,           // RAM read
  input wire logic           ram_we,           // RAM write
  input wire logic           field_valid,      // Field strobe
  input wire logic           svc_done,         // Finished
  input wire logic           engine_busy,      // Running
  input wire logic           list_end,         // End found
  input wire logic           list_header,      // Header found
  input wire svc_pkg::word_t list_finish_time  // Finish time
);
  import svc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  assign take = !engine_busy && (cmd_tx || cmd_rx || cmd_list);

  property p_read_follows;
    take |=> ram_rd;
  endproperty
  a_read_follows: assert property (p_read_follows)
    else $error("no read after command");
  property p_ptr_read;
    take && !cmd_list
      |=> ram_addr == addr_t'(PTR_TABLE_BASE + $past(svc_index));
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("pointer word address wrong");
  property p_list_read;
    take && cmd_list |=> ram_addr == $past(list_addr);
  endproperty
  a_list_read: assert property (p_list_read)
    else $error("list word address wrong");
  property p_end_found;
    take && cmd_list ##2 ram_rdata[15:14] == 2'b11 |-> ##3 list_end;
  endproperty
  a_end_found: assert property (p_end_found)
    else $error("end marker missed");
  property p_header_found;
    take && cmd_list ##2 !ram_rdata[15] |-> ##1 list_header;
  endproperty
  a_header_found: assert property (p_header_found)
    else $error("header missed");
  property p_time_read;
    take && cmd_list ##2 ram_rdata[15:14] == 2'b11
      |-> ##1 ram_rd && ram_addr == addr_t'($past(list_addr, 3) + 11'h001);
  endproperty
  a_time_read: assert property (p_time_read)
    else $error("second end word not read");
  property p_time_kept;
    list_end |-> list_finish_time == $past(ram_rdata);
  endproperty
  a_time_kept: assert property (p_time_kept)
    else $error("finish time not captured");
  property p_writeback;
    svc_done && ram_we |-> $past(ram_we) && $past(ram_we, 2)
      && $past(ram_we, 3) && $past(ram_we, 4)
      && ram_addr == addr_t'($past(ram_addr, 4) + 11'h004);
  endproperty
  a_writeback: assert property (p_writeback)
    else $error("control words not written back");

  c_end: cover property (list_end);
  c_field: cover property (field_valid);
  c_writeback: cover property (ram_we [*4] ##1 (ram_we && svc_done));
endmodule : svc_engine_properties

/* dv/svc_ram_model.sv */
`timescale 1ns/1ps
module svc_ram_model
  import svc_pkg::*;
(
  input  wire logic           clk,       // Clock
  input  wire svc_pkg::addr_t ram_addr,  // Word address
  input  wire logic           ram_rd,    // Read strobe
  input  wire logic           ram_we,    // Write strobe
  input  wire svc_pkg::word_t ram_wdata, // Write data
  output svc_pkg::word_t      ram_rdata  // Read data
);
  import svc_pkg::*;
  word_t mem [0:2047];
  initial ram_rdata = 16'hA5A5;
  // Outside a read the data lines toggle so stale values never match
  always @(posedge clk)
  begin
    if (ram_we)
      mem[ram_addr] <= ram_wdata;
    if (ram_rd)
      ram_rdata <= mem[ram_addr];
    else
      ram_rdata <= ~ram_rdata;
  end
endmodule : svc_ram_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import svc_pkg::*;
  logic clk = 1'b0, reset = 1'b1, cmd_tx = 1'b0, cmd_rx = 1'b0;
  logic cmd_list = 1'b0, svc_role_select = 1'b0, rx_handshake = 1'b0;
  logic rx_busy = 1'b0, rx_error = 1'b0, rx_cmd_change = 1'b0;
  logic rx_good = 1'b0, rx_direction = 1'b0, fault_protocol = 1'b0;
  logic fault_hs_timeout = 1'b0, fault_busy_timeout = 1'b0;
  logic [2:0] svc_index = 3'h0, rx_element_code = 3'h0;
  logic [63:0] rx_words = 64'h0;
  addr_t list_addr = 11'h000, ram_addr;
  word_t ram_rdata, ram_wdata, svc_field, info_word, list_finish_time;
  logic ram_rd, ram_we, field_valid, info_valid, svc_done, engine_busy;
  logic list_end, list_header;
  int mismatches = 0, comparisons = 0, base, w[5], bm[256], ei[$];
  word_t iq[$], fld, ftime;
  logic fseen, lend, lhead;

  svc_engine svc_engine_inst (.clk, .reset, .cmd_tx, .cmd_rx, .cmd_list,
    .svc_index, .svc_role_select, .list_addr, .rx_handshake, .rx_busy,
    .rx_error, .rx_cmd_change, .rx_good, .rx_element_code, .rx_direction,
    .rx_words, .fault_protocol, .fault_hs_timeout, .fault_busy_timeout,
    .ram_rdata, .ram_addr, .ram_rd, .ram_we, .ram_wdata, .svc_field,
    .field_valid, .info_valid, .info_word, .svc_done, .engine_busy,
    .list_end, .list_header, .list_finish_time);
  svc_ram_model svc_ram_model_inst (.clk, .ram_addr, .ram_rd, .ram_we,
    .ram_wdata, .ram_rdata);

  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (info_valid)
      iq.push_back(info_word);
    if (field_valid)
      {fseen, fld} = {1'b1, svc_field};
    if (list_end)
      {lend, ftime} = {1'b1, list_finish_time};
    if (list_header)
      lhead = 1'b1;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic chk(string what, int e, logic [15:0] g);
    comparisons++;
    if (g !== 16'(e))
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, 16'(e), g);
    end
  endtask : chk

  // Command is held a second cycle, which a busy engine must ignore
  task automatic issue(int k);
    int n;
    {fseen, lend, lhead} = 3'b000;
    iq.delete();
    {cmd_tx, cmd_rx, cmd_list} = {k == 0 || k == 2, k == 1, k == 2};
    repeat (2) @(negedge clk);
    {cmd_tx, cmd_rx, cmd_list} = 3'b000;
    for (n = 0; svc_done !== 1'b1; n++)
    begin
      @(negedge clk);
      if (n > 400)
      begin
        mismatches++;
        complete_run();
      end
    end
    // One more cycle lets the last write-back and end pulses land
    @(negedge clk);
  endtask : issue

  task automatic prep(int n, bit stall);
    int c;
    base = 'h40 + n * 'hF0;
    w[0] = ($urandom & 'h03FF) | (stall ? 'h1000 << ($urandom % 2) : 0);
    w[1] = $urandom & 'h038F;
    c = $urandom % 250;
    w[2] = ((c + $urandom % 4) << 8) | c;
    c = $urandom % 250;
    w[3] = ((c + $urandom % 4) << 8) | c;
    w[4] = ($urandom & 'h1FFF) | ($urandom % 4 == 0 ? 'hFF : 0);
    svc_ram_model_inst.mem[2 + n] = 16'(base);
    for (int i = 0; i < 5; i++)
      svc_ram_model_inst.mem[base + i] = 16'(w[i]);
    for (int j = 0; j < 256; j++)
    begin
      bm[j] = $urandom & 'hFFFF;
      svc_ram_model_inst.mem[base + 5 + j] = 16'(bm[j]);
    end
  endtask : prep

  // Moves info words and stops at the final index with its end flag
  task automatic move(int wi, int cnt, int fb);
    int idx;
    for (int k = 0; k < cnt; k++)
    begin
      idx = w[wi] & 'hFF;
      if (wi == 2)
        ei.push_back(bm[idx]);
      else
        bm[idx] = rx_words[16 * k +: 16];
      if (idx == (w[wi] >> 8))
      begin
        w[0] |= fb;
        break;
      end
      w[wi]++;
    end
  endtask : move

  task automatic step(int t);
    int k, ef, mask;
    bit hold;
    k = $urandom % 2;
    svc_index = 3'($urandom);
    svc_role_select = 1'($urandom);
    prep(svc_index, t % 4 == 3);
    {rx_handshake, rx_busy, rx_cmd_change, rx_good, rx_direction} =
      5'($urandom);
    {fault_protocol, fault_hs_timeout, fault_busy_timeout} = 3'($urandom);
    rx_error = 1'($urandom) & (w[0][1] | !rx_good);
    rx_element_code = 3'(t);
    rx_words = {$urandom, $urandom};
    hold = (w[0] & (svc_role_select ? 'h7000 : 'h3000)) != 0;
    ei.delete();
    if (k == 0 && svc_role_select)
    begin
      ef = (w[0] & 'h3F) | ((w[0] >> 4) & 4);
      w[0] |= ef & 4;
      mask = 'h3F;
    end
    if (k == 0 && !svc_role_select)
    begin
      ef = (w[0] & 'hF) | ((((w[0] >> 12) | (w[0] >> 13)) & 1) << 1);
      mask = 'hF;
    end
    if (k == 0 && !hold)
      move(2, ((w[0] >> 8) & 3) + 1, 'h2000);
    if (k == 1 && svc_role_select)
    begin
      if ((w[4] & 'hFF) != 'hFF && ((w[4] & 'h100) ? rx_busy
          : rx_handshake != w[0][0]))
        w[4]++;
      w[1] = (w[1] & 'hFF70) | {rx_cmd_change, rx_error, rx_busy,
        rx_handshake} | (!rx_good << 7);
      w[0] |= rx_error << 12;
      w[4] |= {rx_cmd_change, fault_busy_timeout, fault_hs_timeout,
        fault_protocol} << 9;
      if (!hold && !w[0][1] && rx_good)
        move(3, ((w[1] >> 8) & 3) + 1, 'h4000);
    end
    if (k == 1 && !svc_role_select && ((w[0] >> 4) & 'hF) !=
        {rx_direction, rx_element_code})
      w[0] = (w[0] & 'hEF0F) | ({rx_direction, rx_element_code} << 4)
        | 'h1000;
    if (svc_role_select)
      w[0] = (w[0] & 'hFF7F) | (((w[0] & 'h7000) != 0) << 7);
    else
      w[0] |= ((w[0] & 'h3000) != 0) << 1;
    issue(k);
    if (k == 0)
    begin
      chk("field strobe", 1, fseen);
      chk("field", ef, fld & 16'(mask));
    end
    chk("info count", ei.size(), 16'(iq.size()));
    for (int i = 0; i < ei.size() && i < iq.size(); i++)
      chk("info word", ei[i], iq[i]);
    for (int i = 0; i < 5; i++)
      chk("control word", w[i], svc_ram_model_inst.mem[base + i]);
    for (int j = 0; j < 256; j++)
      chk("buffer word", bm[j], svc_ram_model_inst.mem[base + 5 + j]);
    $display("container test %0d done", t);
  endtask : step

  task automatic list_test(int t);
    int a, tm;
    a = 'h7E0 + $urandom % 16;
    tm = $urandom & 'hFFFF;
    svc_ram_model_inst.mem[a] = 16'(((t % 4) << 14) | ($urandom & 'h3FFF));
    svc_ram_model_inst.mem[a + 1] = 16'(tm);
    list_addr = 11'(a);
    issue(2);
    chk("list end", t % 4 == 3, lend);
    chk("list header", t % 4 < 2, lhead);
    if (t % 4 == 3)
      chk("finish time", tm, ftime);
    $display("list test %0d done", t);
  endtask : list_test

  initial
  begin
    void'($urandom(32'h789E5CF9));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    for (int t = 0; t < 48; t++)
      step(t);
    for (int t = 0; t < 12; t++)
      list_test(t);
    cmd_tx = 1'b1;
    @(negedge clk);
    cmd_tx = 1'b0;
    repeat (6) @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    chk("busy in reset", 0, engine_busy);
    chk("field in reset", 0, svc_field);
    reset = 1'b0;
    $display("reset test done");
    step(5);
    complete_run();
  end
endmodule : testbench

bind svc_engine svc_engine_properties svc_engine_properties_inst (
  .clk, .reset, .cmd_tx, .cmd_rx, .cmd_list, .svc_index, .list_addr,
  .ram_rdata, .ram_addr, .ram_rd, .ram_we, .field_valid, .svc_done,
  .engine_busy, .list_end, .list_header, .list_finish_time);
